/* hdl/pcs_command_trigger.sv */
`timescale 1ns/100ps
`include "pcs_regs.svh"
// Operation
// (RULE_01) poll command turns next read into acknowledge
// (RULE_02) read select picks pending or in-service bits
// (RULE_03) read select clear leaves selection unchanged
// (RULE_04) status selection retained across reads
// (RULE_05) init completion defaults reads to pending bits
// (RULE_06) enable bit gates special mask mode change
// (RULE_07) command word decoded only when bits 4:3 are 01
// (RULE_08) command ports at 020h and 0A0h
// (RULE_09) reset selects pending bits, special mask off
// (RULE_10) two trigger select registers at 04D0h, 04D1h
// (RULE_11) software keeps inputs 0,1,2,8,13 edge triggered
// (RULE_12) reset clears trigger select registers to 00h
// (RULE_13) bit 0 edge, 1 level; low/high registers
// (RULE_14) level-to-edge switch latches request even masked
// (RULE_15) special mask mode ignores in-service priority
module pcs_command_trigger #(
	parameter int NUM_INPUTS = 8
) (
	input wire logic clk_sys,
	input wire logic reset,
	input wire logic [15:0] io_addr,
	input wire logic io_wr,
	input wire logic io_rd,
	input wire pcs_pkg::pcs_byte_type io_wdata,
	output pcs_pkg::pcs_byte_type io_rdata,
	output logic io_rdata_valid,
	output logic io_claim,
	input wire logic [15:0] irq_line,
	input wire logic [15:0] irq_mask,
	input wire logic [15:0] in_service,
	input wire logic [1:0] init_done,
	output logic [1:0] init_word_write,
	output logic [1:0] int_req,
	output logic [1:0] poll_ack,
	output logic [2:0] poll_ack_level,
	output logic [1:0] special_mask_mode,
	output logic [15:0] trigger_select
);
	import pcs_pkg::*;

	// refused at elaboration, the priority logic is eight inputs wide
	if (NUM_INPUTS != 8) begin : g_bad_inputs
		$error("pcs_command_trigger serves exactly eight inputs per controller");
	end

	// ==========================================================
	// helpers

	function automatic logic [15:0] cmd_port(input logic idx);
		return idx ? `PCS_PORT_CMD_SECOND : `PCS_PORT_CMD_FIRST; // see (RULE_08)
	endfunction : cmd_port

	// returns {found, level}; fixed priority, level 0 highest
	function automatic logic [3:0] pick_level(
		input logic [7:0] req,
		input logic [7:0] svc,
		input logic [7:0] mask,
		input logic special_mask_set
	);
		logic [7:0] elig;
		logic [3:0] result;
		logic blocked;
		elig = req & ~mask;
		result = 4'h0;
		blocked = 1'b0;
		if (special_mask_set) begin
			elig = elig & ~svc; // see (RULE_15)
		end
		for (int i = 0; i < 8; i++) begin
			if (!blocked && !result[3]) begin
				if (elig[i]) begin
					result = {1'b1, 3'(i)};
				end else if (svc[i] && !special_mask_set) begin
					blocked = 1'b1;
				end
			end
		end
		return result;
	endfunction : pick_level

	// ==========================================================
	// trigger select registers

	logic [7:0] trig_low_reg, trig_low_next;
	logic [7:0] trig_high_reg, trig_high_next;

	always_comb begin
		trig_low_next = trig_low_reg;
		trig_high_next = trig_high_reg;
		if (io_wr && io_addr == `PCS_PORT_TRIG_LOW) begin
			trig_low_next = io_wdata; // see (RULE_10)
		end
		if (io_wr && io_addr == `PCS_PORT_TRIG_HIGH) begin
			trig_high_next = io_wdata; // see (RULE_10)
		end
	end

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			trig_low_reg <= `PCS_TRIG_RESET; // see (RULE_12)
			trig_high_reg <= `PCS_TRIG_RESET; // see (RULE_12)
		end else begin
			trig_low_reg <= trig_low_next;
			trig_high_reg <= trig_high_next;
		end
	end

	// high register covers inputs 8 to 15
	assign trigger_select = {trig_high_reg, trig_low_reg}; // see (RULE_13)

	// ==========================================================
	// request latches

	logic [15:0] pending;
	logic [15:0] ack_vec;

	pcs_req_latch #(
		.WIDTH(16)
	) pcs_req_latch_inst (
		.clk_sys(clk_sys),
		.reset(reset),
		.irq_line(irq_line),
		.level_sel(trigger_select),
		.ack(ack_vec),
		.pending(pending)
	);

	// ==========================================================
	// command word state per controller

	pcs_read_sel_type read_sel_reg [2];
	pcs_read_sel_type read_sel_next [2];
	logic [1:0] smm_reg, smm_next;
	logic [1:0] poll_armed_reg, poll_armed_next;
	logic [1:0] init_wr_reg, init_wr_next;
	logic [1:0] poll_ack_reg, poll_ack_next;
	logic [2:0] poll_level_reg, poll_level_next;
	pcs_byte_type rdata_reg, rdata_next;
	logic rvalid_reg, rvalid_next;
	logic [3:0] pick [2];
	logic [1:0] hit_cmd, hit_data;
	logic hit_trig;

	always_comb begin
		for (int c = 0; c < 2; c++) begin
			pick[c] = pick_level(pending[c*8 +: 8], in_service[c*8 +: 8],
				irq_mask[c*8 +: 8], smm_reg[c]);
			hit_cmd[c] = io_addr == cmd_port(c[0]);
			hit_data[c] = io_addr == cmd_port(c[0]) + `PCS_PORT_DATA_STEP;
		end
		hit_trig = io_addr == `PCS_PORT_TRIG_LOW || io_addr == `PCS_PORT_TRIG_HIGH;
	end

	always_comb begin
		ack_vec = '0;
		rdata_next = rdata_reg;
		rvalid_next = 1'b0;
		poll_ack_next = 2'b00;
		poll_level_next = poll_level_reg;
		init_wr_next = 2'b00;
		for (int c = 0; c < 2; c++) begin
			read_sel_next[c] = read_sel_reg[c];
			smm_next[c] = smm_reg[c];
			poll_armed_next[c] = poll_armed_reg[c];
			// read side first so a same-cycle write can re-arm the poll
			if (io_rd && (hit_cmd[c] || hit_data[c]) && poll_armed_reg[c]) begin
				rdata_next = {pick[c][3], 4'h0, pick[c][2:0]}; // see (RULE_01)
				rvalid_next = 1'b1;
				poll_armed_next[c] = 1'b0;
				if (pick[c][3]) begin
					ack_vec[c*8 + int'(pick[c][2:0])] = 1'b1;
					poll_ack_next[c] = 1'b1;
					poll_level_next = pick[c][2:0];
				end
			end else if (io_rd && hit_cmd[c]) begin
				// selection held, no write needed before each read
				rdata_next = (read_sel_reg[c] == pcs_read_service) ?
					in_service[c*8 +: 8] : pending[c*8 +: 8]; // see (RULE_04)
				rvalid_next = 1'b1;
			end
			if (io_wr && hit_cmd[c]) begin
				if (io_wdata[`PCS_BIT_FIRST_INIT_WORD]) begin
					init_wr_next[c] = 1'b1; // see (RULE_07)
				end else if (io_wdata[`PCS_BIT_THIRD_CMD_SELECT]) begin // see (RULE_07)
					poll_armed_next[c] = io_wdata[`PCS_BIT_POLL]; // see (RULE_01)
					if (io_wdata[`PCS_BIT_SPECIAL_MASK_WE]) begin
						smm_next[c] = io_wdata[`PCS_BIT_SPECIAL_MASK_SET]; // see (RULE_06)
					end
					if (io_wdata[`PCS_BIT_READ_SELECT_EN]) begin // see (RULE_03)
						read_sel_next[c] = io_wdata[`PCS_BIT_READ_SELECT_SRC] ?
							pcs_read_service : pcs_read_request; // see (RULE_02)
					end
				end
			end
			if (init_done[c]) begin
				read_sel_next[c] = pcs_read_request; // see (RULE_05)
				smm_next[c] = `PCS_SPECIAL_MASK_RESET;
				poll_armed_next[c] = `PCS_POLL_ARMED_RESET;
			end
		end
		if (io_rd && hit_trig) begin
			rdata_next = (io_addr == `PCS_PORT_TRIG_LOW) ? trig_low_reg : trig_high_reg;
			rvalid_next = 1'b1;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			for (int c = 0; c < 2; c++) begin
				read_sel_reg[c] <= pcs_read_request; // see (RULE_09)
			end
			smm_reg <= {2{`PCS_SPECIAL_MASK_RESET}}; // see (RULE_09)
			poll_armed_reg <= {2{`PCS_POLL_ARMED_RESET}};
			init_wr_reg <= 2'b00;
			poll_ack_reg <= 2'b00;
			poll_level_reg <= 3'h0;
			rdata_reg <= 8'h00;
			rvalid_reg <= 1'b0;
		end else begin
			for (int c = 0; c < 2; c++) begin
				read_sel_reg[c] <= read_sel_next[c];
			end
			smm_reg <= smm_next;
			poll_armed_reg <= poll_armed_next;
			init_wr_reg <= init_wr_next;
			poll_ack_reg <= poll_ack_next;
			poll_level_reg <= poll_level_next;
			rdata_reg <= rdata_next;
			rvalid_reg <= rvalid_next;
		end
	end

	// ==========================================================
	// outputs

	// data ports are only claimed while a poll is pending there
	assign io_claim = io_rd && (hit_trig || (|hit_cmd) ||
		(|(hit_data & poll_armed_reg)));
	assign io_rdata = rdata_reg;
	assign io_rdata_valid = rvalid_reg;
	assign init_word_write = init_wr_reg;
	assign poll_ack = poll_ack_reg;
	assign poll_ack_level = poll_level_reg;
	assign special_mask_mode = smm_reg;
	assign int_req = {pick[1][3], pick[0][3]};

endmodule : pcs_command_trigger

/* hdl/pcs_regs.svh */
`ifndef PCS_REGS_SVH
`define PCS_REGS_SVH

// ==========================================================
// port addresses
`define PCS_PORT_CMD_FIRST 16'h0020
`define PCS_PORT_CMD_SECOND 16'h00a0
`define PCS_PORT_TRIG_LOW 16'h04d0
`define PCS_PORT_TRIG_HIGH 16'h04d1
`define PCS_PORT_DATA_STEP 16'h0001

// ==========================================================
// command word field positions
`define PCS_BIT_SPECIAL_MASK_SET 6
`define PCS_BIT_SPECIAL_MASK_WE 5
`define PCS_BIT_FIRST_INIT_WORD 4
`define PCS_BIT_THIRD_CMD_SELECT 3
`define PCS_BIT_POLL 2
`define PCS_BIT_READ_SELECT_EN 1
`define PCS_BIT_READ_SELECT_SRC 0
`define PCS_BIT_POLL_VALID 7

// ==========================================================
// reset values
`define PCS_TRIG_RESET 8'h00
`define PCS_SPECIAL_MASK_RESET 1'b0
`define PCS_POLL_ARMED_RESET 1'b0

`endif

/* hdl/pcs_pkg.sv */
package pcs_pkg;

	typedef enum logic {
		pcs_read_request,
		pcs_read_service
	} pcs_read_sel_type;

	typedef logic [7:0] pcs_byte_type;

endpackage : pcs_pkg

/* hdl/pcs_req_latch.sv */
`timescale 1ns/100ps
module pcs_req_latch #(
	parameter int WIDTH = 8
) (
	input wire logic clk_sys,
	input wire logic reset,
	input wire logic [WIDTH-1:0] irq_line,
	input wire logic [WIDTH-1:0] level_sel,
	input wire logic [WIDTH-1:0] ack,
	output logic [WIDTH-1:0] pending
);
	import pcs_pkg::*;

	logic [WIDTH-1:0] line_prev_reg, line_prev_next;
	logic [WIDTH-1:0] level_prev_reg, level_prev_next;
	logic [WIDTH-1:0] pend_reg, pend_next;
	logic [WIDTH-1:0] edge_set;
	logic [WIDTH-1:0] switch_set;

	always_comb begin
		line_prev_next = irq_line;
		level_prev_next = level_sel;
		edge_set = irq_line & ~line_prev_reg & ~level_sel;
		// masking happens downstream, so a masked input still latches here
		switch_set = irq_line & level_prev_reg & ~level_sel; // see (RULE_14)
		// set beats a same-cycle acknowledge so no edge is lost
		pend_next = (pend_reg & ~ack) | edge_set | switch_set;
		pend_next = (pend_next & ~level_sel) | (irq_line & level_sel); // see (RULE_13)
	end

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			line_prev_reg <= '0;
			level_prev_reg <= '0;
			pend_reg <= '0;
		end else begin
			line_prev_reg <= line_prev_next;
			level_prev_reg <= level_prev_next;
			pend_reg <= pend_next;
		end
	end

	assign pending = pend_reg;

endmodule : pcs_req_latch

/* verif/pcs_command_trigger_checker.sv */
`timescale 1ns/100ps
module pcs_command_trigger_checker (
	input wire logic clk_sys,
	input wire logic reset,
	input wire logic [15:0] io_addr,
	input wire logic io_wr,
	input wire logic io_rd,
	input wire pcs_pkg::pcs_byte_type io_wdata,
	input wire pcs_pkg::pcs_byte_type io_rdata,
	input wire logic io_rdata_valid,
	input wire logic io_claim,
	input wire logic [1:0] init_done,
	input wire logic [1:0] init_word_write,
	input wire logic [1:0] special_mask_mode,
	input wire logic [15:0] trigger_select
);
	import pcs_pkg::*;
	default clocking @(posedge clk_sys); endclocking
	default disable iff (reset);
	logic cw;
	// init_done clears mask mode too, so keep it out of the cause
	assign cw = io_wr && io_addr == 16'h0020 && io_wdata[4:3] == 2'b01 && !init_done[0];
	sequence poll_armed;
		cw && io_wdata[2];
	endsequence
	sequence poll_read;
		io_rd && !io_wr && io_addr == 16'h0020;
	endsequence
	// the host model leaves one idle cycle between a write and the next read
	sequence poll_gap;
		!io_rd && !io_wr && !init_done[0];
	endsequence
	a_read_answer: assert property (io_rd && io_claim |=> io_rdata_valid)
		else $error("claimed read gave no data");
	a_no_stray: assert property (!(io_rd && io_claim) |=> !io_rdata_valid)
		else $error("data without a claimed read");
	a_cmd_claimed: assert property (
		io_rd && (io_addr == 16'h0020 || io_addr == 16'h00a0) |-> io_claim)
		else $error("command port not claimed");
	a_reset_clear: assert property (
		$fell(reset) |-> trigger_select == 16'h0000 && special_mask_mode == 2'b00)
		else $error("bad state after reset");
	a_trig_low: assert property (
		io_wr && io_addr == 16'h04d0 |=> trigger_select[7:0] == $past(io_wdata))
		else $error("low trigger byte not written");
	a_trig_high: assert property (
		io_wr && io_addr == 16'h04d1 |=> trigger_select[15:8] == $past(io_wdata))
		else $error("high trigger byte not written");
	a_mask_enter: assert property (
		cw && io_wdata[5] |=> special_mask_mode[0] == $past(io_wdata[6]))
		else $error("mask mode not taken");
	a_mask_hold: assert property (cw && !io_wdata[5] |=> $stable(special_mask_mode[0]))
		else $error("mask mode changed without enable");
	a_init_word: assert property (
		io_wr && io_addr == 16'h0020 |=> init_word_write[0] == $past(io_wdata[4]))
		else $error("init word decode wrong");
	a_poll_byte: assert property (
		poll_armed ##1 poll_gap ##1 poll_read |=> io_rdata_valid && io_rdata[6:3] == 4'h0)
		else $error("poll byte malformed");
endmodule : pcs_command_trigger_checker

bind pcs_command_trigger pcs_command_trigger_checker pcs_command_trigger_checker_inst (
	.clk_sys(clk_sys), .reset(reset), .io_addr(io_addr), .io_wr(io_wr), .io_rd(io_rd),
	.io_wdata(io_wdata), .io_rdata(io_rdata), .io_rdata_valid(io_rdata_valid),
	.io_claim(io_claim), .init_done(init_done), .init_word_write(init_word_write),
	.special_mask_mode(special_mask_mode), .trigger_select(trigger_select));

/* verif/pcs_host_model.sv */
`timescale 1ns/100ps
module pcs_host_model (
	input wire logic clk_sys,
	output logic [15:0] io_addr,
	output logic io_wr,
	output logic io_rd,
	output pcs_pkg::pcs_byte_type io_wdata,
	input wire pcs_pkg::pcs_byte_type io_rdata
);
	import pcs_pkg::*;
	initial begin
		io_addr = 16'h0000;
		io_wr = 1'b0;
		io_rd = 1'b0;
		io_wdata = 8'h00;
	end
	// callers keep command bits 4:3 at 01 unless a refusal is meant
	task automatic wr(input logic [15:0] a, input pcs_byte_type d);
		@(negedge clk_sys);
		io_addr = a;
		io_wdata = d;
		io_wr = 1'b1;
		@(negedge clk_sys);
		io_wr = 1'b0;
		io_wdata = ~d;
	endtask : wr
	task automatic rd(input logic [15:0] a, output pcs_byte_type d);
		@(negedge clk_sys);
		io_addr = a;
		io_rd = 1'b1;
		@(negedge clk_sys);
		io_rd = 1'b0;
		d = io_rdata;
	endtask : rd
endmodule : pcs_host_model

/* verif/pcs_command_trigger_bench.sv */
`timescale 1ns/100ps
module pcs_command_trigger_bench;
	import pcs_pkg::*;
	logic clk_sys = 1'b0;
	logic reset = 1'b1;
	logic [15:0] io_addr, trigger_select;
	logic [15:0] irq_line = 16'h0000, irq_mask = 16'h0000, in_service = 16'h0000;
	logic io_wr, io_rd, io_rdata_valid, io_claim;
	logic [1:0] init_done = 2'b00;
	logic [1:0] init_word_write, int_req, poll_ack, special_mask_mode;
	logic [2:0] poll_ack_level;
	pcs_byte_type io_wdata, io_rdata, rb;
	int bad_count = 0;
	int n_checks = 0;
	always #5 clk_sys = ~clk_sys;
	pcs_command_trigger pcs_command_trigger_inst (.clk_sys(clk_sys), .reset(reset),
		.io_addr(io_addr), .io_wr(io_wr), .io_rd(io_rd), .io_wdata(io_wdata),
		.io_rdata(io_rdata), .io_rdata_valid(io_rdata_valid), .io_claim(io_claim),
		.irq_line(irq_line), .irq_mask(irq_mask), .in_service(in_service),
		.init_done(init_done), .init_word_write(init_word_write), .int_req(int_req),
		.poll_ack(poll_ack), .poll_ack_level(poll_ack_level),
		.special_mask_mode(special_mask_mode), .trigger_select(trigger_select));
	pcs_host_model pcs_host_model_inst (.clk_sys(clk_sys), .io_addr(io_addr), .io_wr(io_wr),
		.io_rd(io_rd), .io_wdata(io_wdata), .io_rdata(io_rdata));
	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		n_checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	task automatic end_of_test;
		$display("checks %0d mismatches %0d", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : end_of_test
	task automatic wr(input logic [15:0] a, input pcs_byte_type d);
		pcs_host_model_inst.wr(a, d);
	endtask : wr
	task automatic rd_chk(input string what, input logic [15:0] a, input pcs_byte_type exp);
		pcs_host_model_inst.rd(a, rb);
		check(what, 16'(rb), 16'(exp));
	endtask : rd_chk
	// inputs 0,1,2,8,13 are never put in level mode
	task automatic drive(input logic [15:0] l, input logic [15:0] m, input logic [15:0] s);
		@(negedge clk_sys);
		irq_line = l;
		irq_mask = m;
		in_service = s;
		repeat (2) @(negedge clk_sys);
	endtask : drive
	// ==========================================================
	// scenarios
	task automatic t_reset_state;
		check("trig", trigger_select, 16'h0000);
		check("smm", 16'(special_mask_mode), 16'h0000);
		rd_chk("trig hi", 16'h04d1, 8'h00);
	endtask : t_reset_state
	task automatic t_trigger;
		wr(16'h04d0, 8'hf8);
		wr(16'h04d1, 8'hde);
		check("trig", trigger_select, 16'hdef8);
		rd_chk("trig lo", 16'h04d0, 8'hf8);
		rd_chk("trig hi", 16'h04d1, 8'hde);
		wr(16'h04d0, 8'h00);
		wr(16'h04d1, 8'h00);
	endtask : t_trigger
	task automatic t_status;
		drive(16'h0808, 16'h0000, 16'h2020);
		rd_chk("irr1", 16'h0020, 8'h08);
		rd_chk("irr2", 16'h00a0, 8'h08);
		wr(16'h0020, 8'h0b);
		rd_chk("isr", 16'h0020, 8'h20);
		rd_chk("isr again", 16'h0020, 8'h20);
		wr(16'h0020, 8'h09);
		wr(16'h0020, 8'h12);
		rd_chk("kept", 16'h0020, 8'h20);
		@(negedge clk_sys);
		init_done = 2'b01;
		@(negedge clk_sys);
		init_done = 2'b00;
		rd_chk("after init", 16'h0020, 8'h08);
	endtask : t_status
	task automatic t_mask;
		drive(16'h0848, 16'h0008, 16'h0020);
		check("normal blocks", 16'(int_req[0]), 16'h0000);
		check("c2 req", 16'(int_req[1]), 16'h0001);
		wr(16'h0020, 8'h68);
		check("smm on", 16'(special_mask_mode), 16'h0001);
		check("smm allows", 16'(int_req[0]), 16'h0001);
		wr(16'h0020, 8'h48);
		check("smm held", 16'(special_mask_mode), 16'h0001);
		wr(16'h0020, 8'h28);
		check("smm off", 16'(special_mask_mode), 16'h0000);
	endtask : t_mask
	task automatic t_poll;
		drive(16'h0848, 16'h0000, 16'h0000);
		wr(16'h0020, 8'h0c);
		rd_chk("poll", 16'h0020, 8'h83);
		check("poll ack", 16'(poll_ack), 16'h0001);
		check("poll level", 16'(poll_ack_level), 16'h0003);
		rd_chk("acked", 16'h0020, 8'h40);
		wr(16'h00a0, 8'h0c);
		rd_chk("poll data port", 16'h00a1, 8'h83);
		check("poll ack 2", 16'(poll_ack), 16'h0002);
	endtask : t_poll
	task automatic t_level_switch;
		wr(16'h04d0, 8'h10);
		drive(16'h0858, 16'h0010, 16'h0000);
		wr(16'h04d0, 8'h00);
		drive(16'h0848, 16'h0010, 16'h0000);
		rd_chk("false req", 16'h0020, 8'h50);
	endtask : t_level_switch
	initial begin
		repeat (4) @(negedge clk_sys);
		reset = 1'b0;
		t_reset_state();
		t_trigger();
		t_status();
		t_mask();
		t_poll();
		t_level_switch();
		end_of_test();
	end
	initial begin
		#20000;
		bad_count++;
		end_of_test();
	end
endmodule : pcs_command_trigger_bench
